// ### src/t16_regs.svh
/*
 * Register indices, field positions, reset values and mode codes of the
 * 16-bit timer compare-output stage.
 * Assumes byte address = 4 * register index on a 32-bit APB.
 */
// Summary of operation
// - Channel B mode is bit 5 (high) joined with bit 4 (low) of control A.
// - Normal and clear-on-match waveform modes use the non-PWM decoding.
// - Output mode 0 disconnects the compare output; pin is ordinary I/O.
// - Non-PWM, mode 1: toggle the output on every compare match.
// - Non-PWM, mode 2: clear the output on compare match.
// - Non-PWM, mode 3: set the output on compare match.
// - Fast PWM, mode 1: toggle A only in waveform 15; B disconnected.
// - Fast PWM, mode 2: clear on match, set when counter hits maximum.
// - Fast PWM, mode 3: set on match, clear when counter hits maximum.
// - Phase-correct, mode 1: toggle A only in waveform 9 or 11.
// - Phase-correct, mode 2: clear on up-count match, set on down-count.
// - Phase-correct, mode 3: set on up-count match, clear on down-count.
// - Waveform mode bits 3 and 2 come from control B bits 4 and 3.
`ifndef T16_REGS_SVH
`define T16_REGS_SVH

// Register indices and byte addresses
`define T16_IDX_CTRL_A 8'h80
`define T16_IDX_CTRL_B 8'h81
`define T16_IDX_STATUS 8'h90
`define T16_ADDR_W 12
`define T16_ADDR_CTRL_A 12'h200
`define T16_ADDR_CTRL_B 12'h204
`define T16_ADDR_STATUS 12'h240

// Reset values
`define T16_CTRL_A_RST 8'h00
`define T16_CTRL_B_RST 8'h00

// Writable bits
`define T16_CTRL_A_WMASK 8'hF3
`define T16_CTRL_B_WMASK 8'hDF

// Control A fields
`define T16_A_MODE_HI 7
`define T16_A_MODE_LO 6
`define T16_B_MODE_HI 5
`define T16_B_MODE_LO 4
`define T16_WAVE_BIT1 1
`define T16_WAVE_BIT0 0

// Control B fields
`define T16_WAVE_BIT3 4
`define T16_WAVE_BIT2 3

// Output-mode codes
`define T16_OM_OFF 2'h0
`define T16_OM_TOGGLE 2'h1
`define T16_OM_CLEAR 2'h2
`define T16_OM_SET 2'h3

// Waveform modes allowing channel A toggle
`define T16_WAVE_FAST_TGL 4'hF
`define T16_WAVE_PC_TGL0 4'h9
`define T16_WAVE_PC_TGL1 4'hB

`endif

// ### src/t16_pkg.sv
/*
 * Types of the 16-bit timer compare-output stage.
 * Assumes the waveform mode codes of the timer's counter core.
 */
`default_nettype none

package t16_pkg;

    typedef enum logic [1:0] {
        T16_GRP_NONPWM,
        T16_GRP_FAST,
        T16_GRP_PHASE
    } t16_wave_grp_t;

    // Waveform mode to decoding group
    function automatic t16_wave_grp_t t16_wave_group(input logic [3:0] wm);
        t16_wave_grp_t g;
        g = T16_GRP_NONPWM;
        unique case (wm)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: g = T16_GRP_PHASE;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: g = T16_GRP_FAST;
            default: g = T16_GRP_NONPWM;
        endcase
        return g;
    endfunction : t16_wave_group

endpackage : t16_pkg

`default_nettype wire

// ### src/t16_chan_out.sv
/*
 * One compare-output channel: pin level and pin ownership.
 * Assumes match, top and direction come from the counter on pclk.
 */
`default_nettype none

module t16_chan_out #(
    parameter bit IS_CHAN_A = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] chan_out_mode,
    input wire logic [3:0] wave_mode_sel,
    input wire logic cmp_match,
    input wire logic cnt_top,
    input wire logic cnt_down,
    output logic cmp_out_pin,
    output logic cmp_out_oe
);
    `include "t16_regs.svh"

    t16_pkg::t16_wave_grp_t grp;
    logic tgl_ok;
    logic conn;
    logic lvl_next;
    logic lvl_reg;
    logic oe_reg;

    assign grp = t16_pkg::t16_wave_group(wave_mode_sel);

    // Toggle allowed for both channels in non-PWM modes, else only for channel A in the listed modes
    assign tgl_ok = (grp == t16_pkg::T16_GRP_NONPWM) ||
        (IS_CHAN_A && grp == t16_pkg::T16_GRP_FAST &&
         wave_mode_sel == `T16_WAVE_FAST_TGL) ||
        (IS_CHAN_A && grp == t16_pkg::T16_GRP_PHASE &&
         (wave_mode_sel == `T16_WAVE_PC_TGL0 ||
          wave_mode_sel == `T16_WAVE_PC_TGL1));

    assign conn = (chan_out_mode != `T16_OM_OFF) &&
        (chan_out_mode != `T16_OM_TOGGLE || tgl_ok);

    // ==========================================================
    // Next pin level
    always_comb begin
        lvl_next = lvl_reg;
        if (conn) begin
            unique case (grp)
                t16_pkg::T16_GRP_NONPWM: begin
                    if (cmp_match) begin
                        unique case (chan_out_mode)
                            `T16_OM_TOGGLE: lvl_next = ~lvl_reg;
                            `T16_OM_CLEAR: lvl_next = 1'b0;
                            `T16_OM_SET: lvl_next = 1'b1;
                            default: lvl_next = lvl_reg;
                        endcase
                    end
                end
                t16_pkg::T16_GRP_FAST: begin
                    // Match wins over top when both arrive together
                    unique case (chan_out_mode)
                        `T16_OM_TOGGLE: begin
                            if (cmp_match) lvl_next = ~lvl_reg;
                        end
                        `T16_OM_CLEAR: begin
                            if (cmp_match) lvl_next = 1'b0;
                            else if (cnt_top) lvl_next = 1'b1;
                        end
                        `T16_OM_SET: begin
                            if (cmp_match) lvl_next = 1'b1;
                            else if (cnt_top) lvl_next = 1'b0;
                        end
                        default: lvl_next = lvl_reg;
                    endcase
                end
                t16_pkg::T16_GRP_PHASE: begin
                    if (cmp_match) begin
                        unique case (chan_out_mode)
                            `T16_OM_TOGGLE: lvl_next = ~lvl_reg;
                            `T16_OM_CLEAR: lvl_next = cnt_down;
                            `T16_OM_SET: lvl_next = ~cnt_down;
                            default: lvl_next = lvl_reg;
                        endcase
                    end
                end
                default: lvl_next = lvl_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            lvl_reg <= lvl_next;
            oe_reg <= conn;
        end
    end

    assign cmp_out_pin = lvl_reg;
    assign cmp_out_oe = oe_reg;

endmodule : t16_chan_out

`default_nettype wire

// ### src/t16_cmp_out.sv
/*
 * APB register file and two compare-output channels of the 16-bit timer.
 * Assumes match, top and count-direction strobes from the counter core on
 * pclk; the pin multiplexer uses the enables to take over the I/O pins.
 */
// The address map and register access over APB were chosen for this implementation.
`default_nettype none

module t16_cmp_out (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_match_a,
    input wire logic cmp_match_b,
    input wire logic cnt_top,
    input wire logic cnt_down,
    output logic [3:0] wave_mode_sel,
    output logic cmp_out_pin_a,
    output logic cmp_out_oe_a,
    output logic cmp_out_pin_b,
    output logic cmp_out_oe_b
);
    `include "t16_regs.svh"

    // ==========================================================
    // Register storage and decode
    logic [7:0] timer16_control_a_reg;
    logic [7:0] timer16_control_b_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic hit_a;
    logic hit_b;
    logic hit_s;
    logic mapped;
    logic setup;
    logic wr_en;
    logic [1:0] chan_a_out_mode;
    logic [1:0] chan_b_out_mode;
    logic [7:0] status_val;

    assign hit_a = paddr == `T16_ADDR_CTRL_A;
    assign hit_b = paddr == `T16_ADDR_CTRL_B;
    assign hit_s = paddr == `T16_ADDR_STATUS;
    assign mapped = hit_a | hit_b | hit_s;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_reg & pwrite & pstrb[0] & mapped;

    assign chan_a_out_mode = {timer16_control_a_reg[`T16_A_MODE_HI],
        timer16_control_a_reg[`T16_A_MODE_LO]};
    assign chan_b_out_mode = {timer16_control_a_reg[`T16_B_MODE_HI],
        timer16_control_a_reg[`T16_B_MODE_LO]};
    assign wave_mode_sel = {timer16_control_b_reg[`T16_WAVE_BIT3],
        timer16_control_b_reg[`T16_WAVE_BIT2],
        timer16_control_a_reg[`T16_WAVE_BIT1],
        timer16_control_a_reg[`T16_WAVE_BIT0]};

    assign status_val = {4'h0, cmp_out_oe_b, cmp_out_pin_b,
        cmp_out_oe_a, cmp_out_pin_a};
    assign prdata_next = hit_a ? {24'h000000, timer16_control_a_reg} :
        hit_b ? {24'h000000, timer16_control_b_reg} :
        hit_s ? {24'h000000, status_val} : 32'h00000000;

    // ==========================================================
    // APB answer: ready in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup) begin
                prdata_reg <= pwrite ? 32'h00000000 : prdata_next;
            end
        end
    end

    // ==========================================================
    // Control registers; status is read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer16_control_a_reg <= `T16_CTRL_A_RST;
            timer16_control_b_reg <= `T16_CTRL_B_RST;
        end else if (wr_en) begin
            if (hit_a) begin
                timer16_control_a_reg <= pwdata[7:0] & `T16_CTRL_A_WMASK;
            end
            if (hit_b) begin
                timer16_control_b_reg <= pwdata[7:0] & `T16_CTRL_B_WMASK;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ==========================================================
    // Compare-output channels
    t16_chan_out #(.IS_CHAN_A(1'b1)) u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .chan_out_mode(chan_a_out_mode),
        .wave_mode_sel(wave_mode_sel),
        .cmp_match(cmp_match_a),
        .cnt_top(cnt_top),
        .cnt_down(cnt_down),
        .cmp_out_pin(cmp_out_pin_a),
        .cmp_out_oe(cmp_out_oe_a)
    );

    t16_chan_out #(.IS_CHAN_A(1'b0)) u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .chan_out_mode(chan_b_out_mode),
        .wave_mode_sel(wave_mode_sel),
        .cmp_match(cmp_match_b),
        .cnt_top(cnt_top),
        .cnt_down(cnt_down),
        .cmp_out_pin(cmp_out_pin_b),
        .cmp_out_oe(cmp_out_oe_b)
    );

endmodule : t16_cmp_out

`default_nettype wire

// ### tb/t16_cmp_out_assertions.sv
/* Port assertions for the timer compare-output block.
   Bound to t16_cmp_out; sees only its ports, one clock domain. */
`default_nettype none
`include "t16_regs.svh"
module t16_cmp_out_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic cmp_match_a,
    input wire logic cnt_top,
    input wire logic cnt_down,
    input wire logic [3:0] wave_mode_sel,
    input wire logic cmp_out_pin_a,
    input wire logic cmp_out_oe_a,
    input wire logic cmp_out_oe_b
);
    // ==========================================
    // Shadow of the channel mode fields
    logic [3:0] om_reg;
    logic wr;
    logic wr_a;
    logic np;
    logic fast;
    assign wr = psel && penable && pready && pwrite && pstrb[0];
    assign wr_a = wr && paddr == `T16_ADDR_CTRL_A;
    assign np = wave_mode_sel inside {4'h0, 4'h4, 4'hC, 4'hD};
    assign fast = wave_mode_sel inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            om_reg <= 4'h0;
        end else if (wr_a) begin
            om_reg <= pwdata[7:4];
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_conn_a;
        wr_a && pwdata[7] ##1 !wr_a;
    endsequence
    AST_WAVE_LO: assert property (
        wr_a |=> wave_mode_sel[1:0] == $past(pwdata[1:0]))
        else $error("wave bits 1:0 not from control A");
    AST_WAVE_HI: assert property (
        wr && paddr == `T16_ADDR_CTRL_B |=>
        wave_mode_sel[3:2] == $past(pwdata[4:3]))
        else $error("wave bits 3:2 not from control B");
    AST_OFF_A: assert property (
        om_reg[3:2] == 2'h0 |=> !cmp_out_oe_a)
        else $error("channel A owns pin in mode 0");
    AST_B_OFF: assert property (
        om_reg[1:0] == 2'h1 && !np |=> !cmp_out_oe_b)
        else $error("channel B connected in PWM mode 1");
    AST_CONN_A: assert property (
        s_conn_a |=> cmp_out_oe_a)
        else $error("channel A not connected in mode 2 or 3");
    AST_TGL: assert property (
        cmp_out_oe_a && om_reg[3:2] == 2'h1 && cmp_match_a |=>
        cmp_out_pin_a != $past(cmp_out_pin_a))
        else $error("channel A did not toggle");
    AST_NP: assert property (
        np && cmp_out_oe_a && om_reg[3] && cmp_match_a |=>
        cmp_out_pin_a == $past(om_reg[2]))
        else $error("non-PWM set or clear wrong");
    AST_FAST: assert property (
        fast && cmp_out_oe_a && om_reg[3] && (cmp_match_a || cnt_top) |=>
        cmp_out_pin_a == ($past(om_reg[2]) ^ !$past(cmp_match_a)))
        else $error("fast PWM level wrong");
    AST_PHASE: assert property (
        !np && !fast && cmp_out_oe_a && om_reg[3] && cmp_match_a |=>
        cmp_out_pin_a == ($past(om_reg[2]) ^ $past(cnt_down)))
        else $error("phase-correct level wrong");
endmodule : t16_cmp_out_assertions
bind t16_cmp_out t16_cmp_out_assertions t16_cmp_out_assertions_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .cmp_match_a(cmp_match_a), .cnt_top(cnt_top),
    .cnt_down(cnt_down), .wave_mode_sel(wave_mode_sel),
    .cmp_out_pin_a(cmp_out_pin_a), .cmp_out_oe_a(cmp_out_oe_a),
    .cmp_out_oe_b(cmp_out_oe_b));
`default_nettype wire

// ### tb/t16_pin_model.sv
/* Shared I/O pad: compare output or port latch, pull-up when input.
   Assumes software owns the direction bit. */
`default_nettype none
module t16_pin_model (
    input wire logic cmp_out_pin,
    input wire logic cmp_out_oe,
    input wire logic port_dir,
    input wire logic port_val,
    output logic pad
);
    assign pad = !port_dir ? 1'b1 : cmp_out_oe ? cmp_out_pin : port_val;
endmodule : t16_pin_model
`default_nettype wire

// ### tb/tb_top.sv
/* Self-checking bench for t16_cmp_out with a reference model.
   Assumes an APB slave that answers before the timeout. */
`default_nettype none
`include "t16_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic mat_a = 1'b0;
    logic mat_b = 1'b0;
    logic top = 1'b0;
    logic down = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pin_a, oe_a, pin_b, oe_b, pad_a, err;
    logic [3:0] wms;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int pa = 0;
    int pb = 0;
    t16_cmp_out t16_cmp_out_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_match_a(mat_a), .cmp_match_b(mat_b), .cnt_top(top),
        .cnt_down(down), .wave_mode_sel(wms), .cmp_out_pin_a(pin_a),
        .cmp_out_oe_a(oe_a), .cmp_out_pin_b(pin_b), .cmp_out_oe_b(oe_b));
    t16_pin_model t16_pin_model_i (.cmp_out_pin(pin_a), .cmp_out_oe(oe_a),
        .port_dir(1'b1), .port_val(1'b0), .pad(pad_a));
    always #50 pclk = ~pclk;
    // ==========================================
    // Reporting and bus tasks
    task summarize();
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            summarize();
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ==========================================
    // Reference model
    function automatic int oe_f(int ch, int wm, int m);
        if (m == 0) return 0;
        if (m > 1 || wm inside {0, 4, 12, 13}) return 1;
        return int'(ch == 0 && wm inside {9, 11, 15});
    endfunction : oe_f
    function automatic int nxt(int wm, int m, int p, int mt, int tp, int dn);
        if (mt && m == 1) return int'(!p);
        if (wm inside {0, 4, 12, 13}) return mt ? int'(m == 3) : p;
        if (wm inside {5, 6, 7, 14, 15}) begin
            return mt ? int'(m == 3) : tp ? int'(m == 2) : p;
        end
        return mt ? int'(m == 3) ^ dn : p;
    endfunction : nxt
    task run(input int wm, input int m);
        int mb, i, oa, ob, xa, xb, xt, xd;
        mb = $urandom_range(3);
        apb(1'b1, `T16_ADDR_CTRL_A, 8'(m * 64 + mb * 16 + 12 + wm % 4));
        apb(1'b1, `T16_ADDR_CTRL_B, 8'(wm / 4 * 8 + 32));
        apb(1'b0, `T16_ADDR_CTRL_A, 8'h00);
        chk("ctrl_a", rd, m * 64 + mb * 16 + wm % 4);
        apb(1'b0, `T16_ADDR_CTRL_B, 8'h00);
        chk("ctrl_b", rd, wm / 4 * 8);
        chk("wave", {28'h0, wms}, wm);
        oa = oe_f(0, wm, m);
        ob = oe_f(1, wm, mb);
        for (i = 0; i < 25; i++) begin
            xa = (i < 24) ? $urandom_range(1) : 0;
            xb = (i < 24) ? $urandom_range(1) : 0;
            xt = (i < 24) ? $urandom_range(1) : 0;
            xd = $urandom_range(1);
            @(posedge pclk);
            mat_a <= 1'(xa);
            mat_b <= 1'(xb);
            top <= 1'(xt);
            down <= 1'(xd);
            @(negedge pclk);
            chk("oe_a", {31'h0, oe_a}, oa);
            chk("oe_b", {31'h0, oe_b}, ob);
            chk("pin_a", {31'h0, pin_a}, pa);
            chk("pin_b", {31'h0, pin_b}, pb);
            chk("pad_a", {31'h0, pad_a}, oa ? pa : 0);
            if (oa) pa = nxt(wm, m, pa, xa, xt, xd);
            if (ob) pb = nxt(wm, mb, pb, xb, xt, xd);
        end
        apb(1'b0, `T16_ADDR_STATUS, 8'h00);
        chk("status", rd, ob * 8 + pb * 4 + oa * 2 + pa);
    endtask : run
    // ==========================================
    // Main sequence
    initial begin
        int waves[8] = '{0, 4, 12, 15, 14, 5, 9, 11};
        void'($urandom(24));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `T16_ADDR_CTRL_A, 8'h00);
        chk("ctrl_a_rst", rd, 0);
        apb(1'b0, `T16_ADDR_CTRL_B, 8'h00);
        chk("ctrl_b_rst", rd, 0);
        apb(1'b1, 12'h3FC, 8'hFF);
        chk("slverr", {31'h0, err}, 1);
        pstrb <= 4'h0;
        apb(1'b1, `T16_ADDR_CTRL_A, 8'hC0);
        pstrb <= 4'hF;
        apb(1'b0, `T16_ADDR_CTRL_A, 8'h00);
        chk("strb_off", rd, 0);
        foreach (waves[w]) begin
            for (int m = 0; m < 4; m++) begin
                run(waves[w], m);
            end
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
